// >>> rtl/ppr_pkg.sv
/*
 * Constants for the peripheral pin remap configuration block: register offset,
 * field positions, field encodings and reset value.
 * Assumes a 32-bit plain register port with byte addresses.
 */
package ppr_pkg;
	localparam logic [7:0]  PPR_REMAP0_OFFSET    = 8'h04;
	localparam logic [31:0] PPR_REMAP0_RESET     = 32'h0000_0000;
	localparam logic [31:0] PPR_REMAP0_WMASK     = 32'h3755_fff0;
	localparam logic [31:0] PPR_REMAP0_RMASK     = 32'h3055_fff0;
	localparam int          PPR_TRIG1_SOF_BIT    = 29;
	localparam int          PPR_SPI2_BIT         = 28;
	localparam int          PPR_DBG_HI           = 26;
	localparam int          PPR_DBG_LO           = 24;
	localparam int          PPR_CAN1_BIT         = 22;
	localparam int          PPR_ADC1_TRG_BIT     = 20;
	localparam int          PPR_ADC0_TRG_BIT     = 18;
	localparam int          PPR_TE_CH3_BIT       = 16;
	localparam int          PPR_OSC_PD_BIT       = 15;
	localparam int          PPR_CAN0_HI          = 14;
	localparam int          PPR_CAN0_LO          = 13;
	localparam int          PPR_TD_BIT           = 12;
	localparam int          PPR_TC_HI            = 11;
	localparam int          PPR_TC_LO            = 10;
	localparam int          PPR_TB_HI            = 9;
	localparam int          PPR_TB_LO            = 8;
	localparam int          PPR_TA_HI            = 7;
	localparam int          PPR_TA_LO            = 6;
	localparam int          PPR_US_HI            = 5;
	localparam int          PPR_US_LO            = 4;
	localparam logic [1:0]  PPR_MOVE_NONE        = 2'h0;
	localparam logic [1:0]  PPR_MOVE_01          = 2'h1;
	localparam logic [1:0]  PPR_MOVE_10          = 2'h2;
	localparam logic [1:0]  PPR_MOVE_FULL        = 2'h3;
	localparam logic [2:0]  PPR_DBG_ALL          = 3'h0;
	localparam logic [2:0]  PPR_DBG_NO_JRST      = 3'h1;
	localparam logic [2:0]  PPR_DBG_SW_ONLY      = 3'h2;
	localparam logic [2:0]  PPR_DBG_NONE         = 3'h4;

	typedef enum logic [1:0] {
		PPR_POS_DEFAULT,
		PPR_POS_PARTIAL,
		PPR_POS_FULL
	} ppr_pos_t;
endpackage : ppr_pkg

// >>> rtl/ppr_field_decode.sv
/*
 * Decodes one two-bit remap field into a pin placement.
 * Assumes the caller names which code means partial; the other unused code
 * and the zero code both leave the pins at default.
 */
`timescale 1ns/1ps
`default_nettype none
module ppr_field_decode
	import ppr_pkg::*;
#(
	parameter logic [1:0] PARTIAL_CODE = PPR_MOVE_10
) (
	input  wire logic [1:0] field,
	output ppr_pos_t        pos
);
	always_comb begin
		if (field == PPR_MOVE_FULL) begin
			pos = PPR_POS_FULL;
		end else if (field == PARTIAL_CODE) begin
			pos = PPR_POS_PARTIAL;
		end else begin
			// An unused encoding keeps the signals on their default pins.
			pos = PPR_POS_DEFAULT;
		end
	end
endmodule : ppr_field_decode
`default_nettype wire

// >>> rtl/ppr_remap_config.sv
/*
 * Peripheral pin remap configuration register and the selects it drives.
 * Assumes a plain register port: one-cycle strobes, read data the next cycle.
 */
// Strobed register access was chosen for this implementation.
// Overview of operation
// - Remap register sits at offset 0x04 and resets to all zeros.
// - Bit 29 feeds USB start-of-frame pulse into timer B trigger input 1.
// - Bit 28 moves third serial peripheral pins to the alternate set.
// - Debug-port field bits 26:24 is write-only.
// - Debug field 000 all, 001 no jtag reset, 010 serial only, 100 none.
// - Bit 22 moves second CAN pins from B12/13 to B5/6.
// - Bit 20 picks second ADC trigger: ext line 11 or timer H trigger out.
// - Bit 18 picks first ADC trigger: ext line 11 or timer H trigger out.
// - Bit 16 connects timer E channel 3 to A3 or 40 kHz RC oscillator.
// - Bit 15 puts port D lines 0 and 1 on the oscillator pins.
// - Bits 14:13 place first CAN: default, unused, partial, full.
// - Bit 12 moves timer D channels from B6-9 to D12-15.
// - Bits 11:10 move timer C: default, unused, partial, full.
// - Bits 9:8 move timer B: default, partial, unused, full.
// - Bits 7:6 move timer A: default, partial, unused, full.
// - Bits 5:4 move third USART: default, partial, unused, full.
`timescale 1ns/1ps
`default_nettype none
module ppr_remap_config
	import ppr_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	output logic             timer_b_trigger1_sof_select,
	output logic             third_serial_periph_pin_move,
	output logic             jtag_debug_port_en,
	output logic             serial_wire_debug_port_en,
	output logic             jtag_reset_pin_free,
	output logic             second_can_pin_move,
	output logic             second_adc_trigger_select,
	output logic             first_adc_trigger_select,
	output logic             timer_e_ch3_input_select,
	output logic             osc_pins_as_port_d,
	output ppr_pos_t         first_can_pin_move,
	output logic             timer_d_pin_move,
	output ppr_pos_t         timer_c_pin_move,
	output ppr_pos_t         timer_b_pin_move,
	output ppr_pos_t         timer_a_pin_move,
	output ppr_pos_t         third_usart_pin_move
);
	logic [31:0] remap_reg;
	logic [31:0] remap_next;
	ppr_pos_t    can0_pos;
	ppr_pos_t    tc_pos;
	ppr_pos_t    tb_pos;
	ppr_pos_t    ta_pos;
	ppr_pos_t    us_pos;
	logic [2:0]  dbg;

	function automatic logic hit(input logic [7:0] a);
		hit = (a == PPR_REMAP0_OFFSET);
	endfunction : hit

	// Reserved bits are not stored, so they always read as zero.
	assign remap_next = wdata & PPR_REMAP0_WMASK;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			remap_reg <= PPR_REMAP0_RESET;
		end else if (wr && hit(addr)) begin
			remap_reg <= remap_next;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata <= 32'h0000_0000;
		end else if (rd && hit(addr)) begin
			// The debug field and the low bits outside this block read zero.
			rdata <= remap_reg & PPR_REMAP0_RMASK;
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	ppr_field_decode #(.PARTIAL_CODE(PPR_MOVE_10)) u_can0 (
		.field (remap_reg[PPR_CAN0_HI:PPR_CAN0_LO]),
		.pos   (can0_pos)
	);
	ppr_field_decode #(.PARTIAL_CODE(PPR_MOVE_10)) u_tc (
		.field (remap_reg[PPR_TC_HI:PPR_TC_LO]),
		.pos   (tc_pos)
	);
	ppr_field_decode #(.PARTIAL_CODE(PPR_MOVE_01)) u_tb (
		.field (remap_reg[PPR_TB_HI:PPR_TB_LO]),
		.pos   (tb_pos)
	);
	ppr_field_decode #(.PARTIAL_CODE(PPR_MOVE_01)) u_ta (
		.field (remap_reg[PPR_TA_HI:PPR_TA_LO]),
		.pos   (ta_pos)
	);
	ppr_field_decode #(.PARTIAL_CODE(PPR_MOVE_01)) u_us (
		.field (remap_reg[PPR_US_HI:PPR_US_LO]),
		.pos   (us_pos)
	);

	assign dbg = remap_reg[PPR_DBG_HI:PPR_DBG_LO];

	// Selects are registered once more so every output comes from a flip-flop.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			timer_b_trigger1_sof_select  <= 1'b0;
			third_serial_periph_pin_move <= 1'b0;
			second_can_pin_move          <= 1'b0;
			second_adc_trigger_select    <= 1'b0;
			first_adc_trigger_select     <= 1'b0;
			timer_e_ch3_input_select     <= 1'b0;
			osc_pins_as_port_d           <= 1'b0;
			timer_d_pin_move             <= 1'b0;
		end else begin
			timer_b_trigger1_sof_select  <= remap_reg[PPR_TRIG1_SOF_BIT];
			third_serial_periph_pin_move <= remap_reg[PPR_SPI2_BIT];
			second_can_pin_move          <= remap_reg[PPR_CAN1_BIT];
			second_adc_trigger_select    <= remap_reg[PPR_ADC1_TRG_BIT];
			first_adc_trigger_select     <= remap_reg[PPR_ADC0_TRG_BIT];
			timer_e_ch3_input_select     <= remap_reg[PPR_TE_CH3_BIT];
			osc_pins_as_port_d           <= remap_reg[PPR_OSC_PD_BIT];
			timer_d_pin_move             <= remap_reg[PPR_TD_BIT];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			first_can_pin_move   <= PPR_POS_DEFAULT;
			timer_c_pin_move     <= PPR_POS_DEFAULT;
			timer_b_pin_move     <= PPR_POS_DEFAULT;
			timer_a_pin_move     <= PPR_POS_DEFAULT;
			third_usart_pin_move <= PPR_POS_DEFAULT;
		end else begin
			first_can_pin_move   <= can0_pos;
			timer_c_pin_move     <= tc_pos;
			timer_b_pin_move     <= tb_pos;
			timer_a_pin_move     <= ta_pos;
			third_usart_pin_move <= us_pos;
		end
	end

	// Undefined debug encodings, including those from breaking the one-bit
	// limit, fall back to the reset setting with both ports enabled.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			jtag_debug_port_en        <= 1'b1;
			serial_wire_debug_port_en <= 1'b1;
			jtag_reset_pin_free       <= 1'b0;
		end else begin
			case (dbg)
				PPR_DBG_NO_JRST: begin
					jtag_debug_port_en        <= 1'b1;
					serial_wire_debug_port_en <= 1'b1;
					jtag_reset_pin_free       <= 1'b1;
				end
				PPR_DBG_SW_ONLY: begin
					jtag_debug_port_en        <= 1'b0;
					serial_wire_debug_port_en <= 1'b1;
					jtag_reset_pin_free       <= 1'b1;
				end
				PPR_DBG_NONE: begin
					jtag_debug_port_en        <= 1'b0;
					serial_wire_debug_port_en <= 1'b0;
					jtag_reset_pin_free       <= 1'b1;
				end
				default: begin
					jtag_debug_port_en        <= 1'b1;
					serial_wire_debug_port_en <= 1'b1;
					jtag_reset_pin_free       <= 1'b0;
				end
			endcase
		end
	end

	a_write_stores: assert property (@(posedge clock) disable iff (!rstn)
		wr && hit(addr) |=> remap_reg == ($past(wdata) & PPR_REMAP0_WMASK))
		else $error("remap register did not take masked write data");

	a_reserved_clear: assert property (@(posedge clock) disable iff (!rstn)
		(remap_reg & ~PPR_REMAP0_WMASK) == 32'h0000_0000)
		else $error("remap register holds a bit outside the writable fields");

	a_debug_reads_zero: assert property (@(posedge clock) disable iff (!rstn)
		rd |=> rdata[PPR_DBG_HI:PPR_DBG_LO] == 3'h0)
		else $error("debug field read back nonzero");

	a_readback_value: assert property (@(posedge clock) disable iff (!rstn)
		rd && hit(addr) |=> rdata == ($past(remap_reg) & PPR_REMAP0_RMASK))
		else $error("read data differs from stored fields");

	a_rdata_idle: assert property (@(posedge clock) disable iff (!rstn)
		!(rd && hit(addr)) |=> rdata == 32'h0000_0000)
		else $error("read data nonzero outside a read of the register");

	a_sof_follows: assert property (@(posedge clock) disable iff (!rstn)
		wr && hit(addr) ##1 !(wr && hit(addr)) |=>
		timer_b_trigger1_sof_select == $past(remap_reg[PPR_TRIG1_SOF_BIT]))
		else $error("sof select does not follow bit 29");

	a_spi_follows: assert property (@(posedge clock) disable iff (!rstn)
		third_serial_periph_pin_move == $past(remap_reg[PPR_SPI2_BIT]))
		else $error("serial peripheral move does not follow bit 28");

	a_debug_all: assert property (@(posedge clock) disable iff (!rstn)
		dbg == PPR_DBG_ALL |=>
		jtag_debug_port_en && serial_wire_debug_port_en && !jtag_reset_pin_free)
		else $error("full debug setting not applied");

	a_debug_nojrst: assert property (@(posedge clock) disable iff (!rstn)
		dbg == PPR_DBG_NO_JRST |=>
		jtag_debug_port_en && serial_wire_debug_port_en && jtag_reset_pin_free)
		else $error("debug setting without jtag reset pin not applied");

	a_debug_swonly: assert property (@(posedge clock) disable iff (!rstn)
		dbg == PPR_DBG_SW_ONLY |=> !jtag_debug_port_en && serial_wire_debug_port_en)
		else $error("serial-only debug setting not applied");

	a_debug_none: assert property (@(posedge clock) disable iff (!rstn)
		dbg == PPR_DBG_NONE |=> !jtag_debug_port_en && !serial_wire_debug_port_en)
		else $error("debug disable setting not applied");

	a_can1_follows: assert property (@(posedge clock) disable iff (!rstn)
		second_can_pin_move == $past(remap_reg[PPR_CAN1_BIT]))
		else $error("second CAN move does not follow bit 22");

	a_adc_trig: assert property (@(posedge clock) disable iff (!rstn)
		second_adc_trigger_select == $past(remap_reg[PPR_ADC1_TRG_BIT]) &&
		first_adc_trigger_select == $past(remap_reg[PPR_ADC0_TRG_BIT]))
		else $error("ADC trigger selects do not follow bits 20 and 18");

	a_tech3_osc: assert property (@(posedge clock) disable iff (!rstn)
		timer_e_ch3_input_select == $past(remap_reg[PPR_TE_CH3_BIT]) &&
		osc_pins_as_port_d == $past(remap_reg[PPR_OSC_PD_BIT]))
		else $error("timer E ch3 or oscillator pin select wrong");

	a_can0_default: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_CAN0_HI:PPR_CAN0_LO] == PPR_MOVE_NONE |=>
		first_can_pin_move == PPR_POS_DEFAULT)
		else $error("first CAN zero code moved pins");

	a_can0_unused: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_CAN0_HI:PPR_CAN0_LO] == PPR_MOVE_01 |=>
		first_can_pin_move == PPR_POS_DEFAULT)
		else $error("first CAN unused code did not keep default pins");

	a_can0_part: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_CAN0_HI:PPR_CAN0_LO] == PPR_MOVE_10 |=>
		first_can_pin_move == PPR_POS_PARTIAL)
		else $error("first CAN partial code not decoded");

	a_can0_full: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_CAN0_HI:PPR_CAN0_LO] == PPR_MOVE_FULL |=>
		first_can_pin_move == PPR_POS_FULL)
		else $error("first CAN full code not decoded");

	a_timer_d: assert property (@(posedge clock) disable iff (!rstn)
		timer_d_pin_move == $past(remap_reg[PPR_TD_BIT]))
		else $error("timer D move does not follow bit 12");

	a_timer_c_unused: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TC_HI:PPR_TC_LO] == PPR_MOVE_01 |=> timer_c_pin_move == PPR_POS_DEFAULT)
		else $error("timer C unused code moved pins");

	a_timer_c_part: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TC_HI:PPR_TC_LO] == PPR_MOVE_10 |=> timer_c_pin_move == PPR_POS_PARTIAL)
		else $error("timer C partial code not decoded");

	a_timer_c_full: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TC_HI:PPR_TC_LO] == PPR_MOVE_FULL |=> timer_c_pin_move == PPR_POS_FULL)
		else $error("timer C full code not decoded");

	a_timer_b_part: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TB_HI:PPR_TB_LO] == PPR_MOVE_01 |=> timer_b_pin_move == PPR_POS_PARTIAL)
		else $error("timer B partial code not decoded");

	a_timer_b_unused: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TB_HI:PPR_TB_LO] == PPR_MOVE_10 |=> timer_b_pin_move == PPR_POS_DEFAULT)
		else $error("timer B unused code moved pins");

	a_timer_b_full: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TB_HI:PPR_TB_LO] == PPR_MOVE_FULL |=> timer_b_pin_move == PPR_POS_FULL)
		else $error("timer B full code not decoded");

	a_timer_a_part: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TA_HI:PPR_TA_LO] == PPR_MOVE_01 |=> timer_a_pin_move == PPR_POS_PARTIAL)
		else $error("timer A partial code not decoded");

	a_timer_a_unused: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TA_HI:PPR_TA_LO] == PPR_MOVE_10 |=> timer_a_pin_move == PPR_POS_DEFAULT)
		else $error("timer A unused code moved pins");

	a_timer_a_full: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_TA_HI:PPR_TA_LO] == PPR_MOVE_FULL |=> timer_a_pin_move == PPR_POS_FULL)
		else $error("timer A full code not decoded");

	a_usart_part: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_US_HI:PPR_US_LO] == PPR_MOVE_01 |=>
		third_usart_pin_move == PPR_POS_PARTIAL)
		else $error("third USART partial code not decoded");

	a_usart_unused: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_US_HI:PPR_US_LO] == PPR_MOVE_10 |=>
		third_usart_pin_move == PPR_POS_DEFAULT)
		else $error("third USART unused code moved pins");

	a_usart_full: assert property (@(posedge clock) disable iff (!rstn)
		remap_reg[PPR_US_HI:PPR_US_LO] == PPR_MOVE_FULL |=>
		third_usart_pin_move == PPR_POS_FULL)
		else $error("third USART full code not decoded");
endmodule : ppr_remap_config
`default_nettype wire

// >>> tb/ppr_remap_config_test.sv
/*
 * Self-checking bench for the peripheral pin remap configuration block.
 * Assumes the plain register port: one-cycle strobes, read data in the next cycle only,
 * and remap outputs that follow a write one cycle after the write edge.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module ppr_remap_config_test
	import ppr_pkg::*;
;
	logic        clock;
	logic        rstn;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        tsof, spi_mv, jtag_en, sw_en, jrst_free, can1_mv, adc1_sel, adc0_sel;
	logic        te_sel, osc_pd, td_mv;
	ppr_pos_t    can0_pos, tc_pos, tb_pos, ta_pos, us_pos;
	logic [7:0]  sb;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          bitpos[8] = '{29, 28, 22, 20, 18, 16, 15, 12};
	logic [2:0]  dbg_code[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	logic [2:0]  dbg_exp[4] = '{3'h6, 3'h7, 3'h3, 3'h1};

	assign sb = {tsof, spi_mv, can1_mv, adc1_sel, adc0_sel, te_sel, osc_pd, td_mv};

	ppr_remap_config u_ppr_remap_config (
		.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .timer_b_trigger1_sof_select(tsof),
		.third_serial_periph_pin_move(spi_mv), .jtag_debug_port_en(jtag_en),
		.serial_wire_debug_port_en(sw_en), .jtag_reset_pin_free(jrst_free),
		.second_can_pin_move(can1_mv), .second_adc_trigger_select(adc1_sel),
		.first_adc_trigger_select(adc0_sel), .timer_e_ch3_input_select(te_sel),
		.osc_pins_as_port_d(osc_pd), .first_can_pin_move(can0_pos),
		.timer_d_pin_move(td_mv), .timer_c_pin_move(tc_pos), .timer_b_pin_move(tb_pos),
		.timer_a_pin_move(ta_pos), .third_usart_pin_move(us_pos)
	);

	always #2.5 clock = ~clock;

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// Returns once the written value has reached the remap outputs.
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask : wr_reg

	// Checks the read word in its one cycle and the idle zero after it.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		`CHK("rdata", exp, rdata)
		@(posedge clock);
		#1;
		`CHK("rdata idle", 32'h0, rdata)
	endtask : rd_chk

	function automatic ppr_pos_t pos_of(input logic [1:0] c, input logic part_is_01);
		if (c == 2'h3) return PPR_POS_FULL;
		if (c == (part_is_01 ? 2'h1 : 2'h2)) return PPR_POS_PARTIAL;
		return PPR_POS_DEFAULT;
	endfunction : pos_of

	task automatic chk_fields(input logic [1:0] c);
		`CHK("first can", pos_of(c, 1'b0), can0_pos)
		`CHK("timer c", pos_of(c, 1'b0), tc_pos)
		`CHK("timer b", pos_of(c, 1'b1), tb_pos)
		`CHK("timer a", pos_of(c, 1'b1), ta_pos)
		`CHK("third usart", pos_of(c, 1'b1), us_pos)
	endtask : chk_fields

	task automatic chk_reset();
		`CHK("single selects", 8'h00, sb)
		`CHK("debug outputs", 3'h6, {jtag_en, sw_en, jrst_free})
		chk_fields(2'h0);
	endtask : chk_reset

	initial begin
		#200000;
		n_fail++;
		conclude();
	end

	initial begin
		clock = 1'b0;
		rstn  = 1'b0;
		addr  = 8'h00;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		#1;
		chk_reset();
		rd_chk(PPR_REMAP0_OFFSET, PPR_REMAP0_RESET);
		for (int i = 0; i < 8; i++) begin
			wr_reg(PPR_REMAP0_OFFSET, 32'h1 << bitpos[i]);
			`CHK("single selects", 8'h80 >> i, sb)
			rd_chk(PPR_REMAP0_OFFSET, 32'h1 << bitpos[i]);
		end
		wr_reg(PPR_REMAP0_OFFSET, 32'h3155_fff0);
		`CHK("single selects", 8'hff, sb)
		rd_chk(PPR_REMAP0_OFFSET, 32'h3055_fff0);
		wr_reg(8'h08, 32'h0);
		rd_chk(8'h08, 32'h0);
		rd_chk(PPR_REMAP0_OFFSET, 32'h3055_fff0);
		for (int c = 0; c < 4; c++) begin
			logic [31:0] w;
			w = {17'h0, 2'(c), 1'b0, 2'(c), 2'(c), 2'(c), 2'(c), 4'h0};
			wr_reg(PPR_REMAP0_OFFSET, w);
			chk_fields(2'(c));
			rd_chk(PPR_REMAP0_OFFSET, w);
		end
		for (int i = 0; i < 4; i++) begin
			wr_reg(PPR_REMAP0_OFFSET, {5'h0, dbg_code[i], 24'h0});
			`CHK("debug outputs", dbg_exp[i], {jtag_en, sw_en, jrst_free})
			rd_chk(PPR_REMAP0_OFFSET, 32'h0);
		end
		wr_reg(PPR_REMAP0_OFFSET, 32'h3255_fff0);
		@(posedge clock);
		rstn <= 1'b0;
		#1;
		chk_reset();
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rd_chk(PPR_REMAP0_OFFSET, PPR_REMAP0_RESET);
		conclude();
	end
endmodule : ppr_remap_config_test
`undef CHK
`default_nettype wire
